//--- design/esg_top.sv
`timescale 1ns/1ps
`include "esg_defs.svh"
module esg_top
   import esg_pkg::*;
#(
   parameter int N_OUT     = 8,
   parameter int TBL_DEPTH = 16
)(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        short_press,
   input  wire logic        long_press,
   output logic [7:0]       cmd_pattern,
   output logic             cmd_valid,
   output logic [7:0]       cmd_enable
);

   if (N_OUT < 2 || N_OUT > ESG_MAX_OUT) begin : g_chk_out
      $error("esg_top: N_OUT must lie in 2..8");
   end
   if (TBL_DEPTH < 2 || TBL_DEPTH > ESG_MAX_TBL) begin : g_chk_tbl
      $error("esg_top: TBL_DEPTH must lie in 2..16");
   end

   localparam logic [3:0] NOUT_MAX = 4'(N_OUT);
   localparam logic [4:0] TLEN_MAX = 5'(TBL_DEPTH);

   esg_if    eif ();
   esg_cfg_t c_q;
   esg_cfg_t c_d;
   logic     setup;
   logic     wr_acc;
   logic     tbl_hit;
   logic [2:0] tbl_sel;
   logic [3:0] wr_nout;
   logic [4:0] wr_tlen;
   logic [8:0] wr_liter;

   esg_engine u_eng (
      .pclk        (pclk),
      .presetn     (presetn),
      .short_press (short_press),
      .long_press  (long_press),
      .e           (eif.eng)
   );

   assign setup    = psel && !penable;
   // writes land only at the completing edge of the access phase
   assign wr_acc   = psel && penable && pwrite && !c_q.slverr;
   assign tbl_hit  = (paddr >= `ESG_TBL_BASE) && (paddr <= `ESG_TBL_LAST) && (paddr[1:0] == 2'b00);
   assign tbl_sel  = 3'(paddr[4:2]);
   assign wr_nout  = pwdata[`ESG_NOUT_LSB +: 4];
   assign wr_tlen  = pwdata[`ESG_TLEN_LSB +: 5];
   assign wr_liter = pwdata[`ESG_LITER_LSB +: 9];

   always_comb begin
      c_d = c_q;
      if (setup) begin
         // read data and error are settled in setup so the access phase completes without wait
         c_d.prdata = 32'h0000_0000;
         c_d.slverr = 1'b0;
         case (paddr)
            `ESG_MODE_OFF:  c_d.prdata[`ESG_MODE_BIT] = c_q.mode;
            `ESG_NOUT_OFF:  c_d.prdata[`ESG_NOUT_LSB +: 4] = c_q.nout;
            `ESG_TLEN_OFF:  c_d.prdata[`ESG_TLEN_LSB +: 5] = c_q.tlen;
            `ESG_LITER_OFF: c_d.prdata[`ESG_LITER_LSB +: 9] = c_q.liter;
            `ESG_STAT_OFF: begin
               c_d.prdata[`ESG_STAT_PAT_LSB +: 8] = eif.pat;
               c_d.prdata[`ESG_STAT_CNT_LSB +: 8] = eif.cnt;
               c_d.prdata[`ESG_STAT_NXT_LSB +: 4] = eif.nxt;
               c_d.slverr = pwrite;
            end
            default: begin
               // compare at four bits: eight outputs would not fit the three-bit column index
               if (tbl_hit && ({1'b0, tbl_sel} < NOUT_MAX)) begin
                  c_d.prdata[15:0] = c_q.tbl[tbl_sel];
               end else begin
                  c_d.slverr = 1'b1;
               end
            end
         endcase
      end else if (wr_acc) begin
         case (paddr)
            `ESG_MODE_OFF: c_d.mode = esg_mode_t'(pwdata[`ESG_MODE_BIT]);
            `ESG_NOUT_OFF: begin
               // out-of-range values are dropped, the old setting stays
               if (wr_nout >= `ESG_NOUT_MIN && wr_nout <= NOUT_MAX && pwdata[31:4] == 28'h0) begin
                  c_d.nout = wr_nout;
               end
            end
            `ESG_TLEN_OFF: begin
               if (wr_tlen >= `ESG_TLEN_MIN && wr_tlen <= TLEN_MAX && pwdata[31:5] == 27'h0) begin
                  c_d.tlen = wr_tlen;
               end
            end
            `ESG_LITER_OFF: begin
               if (wr_liter >= `ESG_LITER_MIN && wr_liter <= `ESG_LITER_MAX && pwdata[31:9] == 23'h0) begin
                  c_d.liter = wr_liter;
               end
            end
            default: begin
               if (tbl_hit && ({1'b0, tbl_sel} < NOUT_MAX)) begin
                  c_d.tbl[tbl_sel] = pwdata[15:0];
               end
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         c_q.mode   <= ESG_MODE_COUNT;
         c_q.nout   <= `ESG_NOUT_RST;
         c_q.tlen   <= `ESG_TLEN_RST;
         c_q.liter  <= `ESG_LITER_RST;
         c_q.tbl    <= {ESG_MAX_OUT{`ESG_TBL_RST}};
         c_q.prdata <= 32'h0000_0000;
         c_q.slverr <= 1'b0;
      end else begin
         c_q <= c_d;
      end
   end

   assign eif.mode  = c_q.mode;
   assign eif.nout  = c_q.nout;
   assign eif.tlen  = c_q.tlen;
   assign eif.liter = c_q.liter;
   assign eif.tbl   = c_q.tbl;

   assign pready      = 1'b1;
   assign prdata      = c_q.prdata;
   assign pslverr     = psel && penable && c_q.slverr;
   assign cmd_pattern = eif.pat;
   assign cmd_valid   = eif.vld;
   assign cmd_enable  = eif.mask;

endmodule : esg_top

//--- design/esg_defs.svh
`ifndef ESG_DEFS_SVH
`define ESG_DEFS_SVH

// register byte offsets
`define ESG_MODE_OFF    12'h000
`define ESG_NOUT_OFF    12'h004
`define ESG_TLEN_OFF    12'h008
`define ESG_LITER_OFF   12'h00C
`define ESG_STAT_OFF    12'h010
`define ESG_TBL_BASE    12'h020
`define ESG_TBL_LAST    12'h03C

// field positions
`define ESG_MODE_BIT    0
`define ESG_NOUT_LSB    0
`define ESG_TLEN_LSB    0
`define ESG_LITER_LSB   0
`define ESG_STAT_PAT_LSB  0
`define ESG_STAT_CNT_LSB  8
`define ESG_STAT_NXT_LSB  16

// reset values
`define ESG_NOUT_RST    4'h2
`define ESG_TLEN_RST    5'h02
`define ESG_LITER_RST   9'h001
`define ESG_TBL_RST     16'hFFFF

// legal ranges
`define ESG_NOUT_MIN    4'h2
`define ESG_TLEN_MIN    5'h02
`define ESG_LITER_MIN   9'h001
`define ESG_LITER_MAX   9'h100

`endif

//--- design/esg_pkg.sv
package esg_pkg;

   localparam int ESG_MAX_OUT = 8;
   localparam int ESG_MAX_TBL = 16;

   typedef enum logic {
      ESG_MODE_COUNT = 1'b0,
      ESG_MODE_TABLE = 1'b1
   } esg_mode_t;

   typedef struct packed {
      esg_mode_t                                 mode;
      logic [3:0]                                nout;
      logic [4:0]                                tlen;
      logic [8:0]                                liter;
      logic [ESG_MAX_OUT-1:0][ESG_MAX_TBL-1:0]   tbl;
      logic [31:0]                               prdata;
      logic                                      slverr;
   } esg_cfg_t;

   typedef struct packed {
      logic [7:0] cnt;
      logic [3:0] nxt;
      logic [7:0] pat;
      logic       vld;
   } esg_eng_t;

endpackage : esg_pkg

//--- design/esg_if.sv
`timescale 1ns/1ps
interface esg_if;
   import esg_pkg::*;

   esg_mode_t                                mode;
   logic [3:0]                               nout;
   logic [4:0]                               tlen;
   logic [8:0]                               liter;
   logic [ESG_MAX_OUT-1:0][ESG_MAX_TBL-1:0]  tbl;
   logic [7:0]                               mask;
   logic [7:0]                               pat;
   logic                                     vld;
   logic [7:0]                               cnt;
   logic [3:0]                               nxt;

   modport cfg (output mode, nout, tlen, liter, tbl, input mask, pat, vld, cnt, nxt);
   modport eng (input mode, nout, tlen, liter, tbl, output mask, pat, vld, cnt, nxt);
endinterface : esg_if

//--- design/esg_engine.sv
`timescale 1ns/1ps
`include "esg_defs.svh"
module esg_engine
   import esg_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic short_press,
   input  wire logic long_press,
   esg_if.eng        e
);

   esg_eng_t   s_q;
   esg_eng_t   s_d;
   logic [3:0] nxt_ok;
   logic [3:0] lidx;
   logic [3:0] sel_idx;
   logic [3:0] sel_inc;
   logic [7:0] mask;
   logic [7:0] tbl_bit;

   // only enabled outputs take part, A is bit 0
   for (genvar o = 0; o < ESG_MAX_OUT; o++) begin : g_col
      assign mask[o]    = (4'(o) < e.nout);
      assign tbl_bit[o] = e.tbl[o][sel_idx];
   end

   // a shortened table leaves a stale pointer behind; restart rather than read unused entries
   assign nxt_ok  = ({1'b0, s_q.nxt} < e.tlen) ? s_q.nxt : 4'h0;
   assign lidx    = 4'((e.liter - `ESG_LITER_MIN) % {4'h0, e.tlen});
   assign sel_idx = long_press ? lidx : nxt_ok;
   assign sel_inc = ({1'b0, sel_idx} + 5'h01 >= e.tlen) ? 4'h0 : sel_idx + 4'h1;

   always_comb begin
      s_d     = s_q;
      s_d.vld = 1'b0;
      if (short_press || long_press) begin
         s_d.vld = 1'b1;
         if (e.mode == ESG_MODE_COUNT) begin
            // long press wins when both arrive together
            if (long_press) begin
               s_d.cnt = e.liter[7:0] & mask;
            end else begin
               s_d.cnt = (s_q.cnt + 8'h01) & mask;
            end
            s_d.pat = s_d.cnt;
         end else begin
            s_d.pat = tbl_bit & mask;
            s_d.nxt = sel_inc;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign e.mask = mask;
   assign e.pat  = s_q.pat;
   assign e.vld  = s_q.vld;
   assign e.cnt  = s_q.cnt;
   assign e.nxt  = s_q.nxt;

endmodule : esg_engine

//--- verification/esg_checker.sv
`timescale 1ns/1ps
module esg_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        short_press,
   input wire logic        long_press,
   input wire logic [7:0]  cmd_pattern,
   input wire logic        cmd_valid,
   input wire logic [7:0]  cmd_enable
);
   logic mode_q;
   logic cnt_ok_q;
   wire  press = short_press || long_press;
   // the step check only holds while the pattern still mirrors the count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q   <= 1'b0;
         cnt_ok_q <= 1'b1;
      end else begin
         if (psel && penable && pwrite && paddr == 12'h000) mode_q <= pwdata[0];
         if (press) cnt_ok_q <= !mode_q;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_bad; psel && !penable && paddr == 12'h0FC; endsequence
   sequence s_acc; psel && penable; endsequence
   AST_ANSWER: assert property (press |=> cmd_valid)
      else $error("press not answered");
   AST_QUIET: assert property (!press |=> !cmd_valid)
      else $error("valid without press");
   AST_OFF_ZERO: assert property (cmd_valid |-> (cmd_pattern & ~cmd_enable) == 8'h00)
      else $error("disabled output set");
   AST_EN_SHAPE: assert property (cmd_enable[1:0] == 2'b11 && ((cmd_enable + 8'h01) & cmd_enable) == 8'h00)
      else $error("bad enable mask");
   AST_HOLD: assert property (!cmd_valid |-> $stable(cmd_pattern))
      else $error("pattern moved");
   AST_STEP: assert property (short_press && !long_press && !mode_q && cnt_ok_q
      |=> cmd_pattern == (($past(cmd_pattern) + 8'h01) & cmd_enable)) else $error("bad count step");
   AST_ERR_PHASE: assert property (pslverr |-> s_acc)
      else $error("error outside access");
   AST_READY: assert property (s_acc |-> pready)
      else $error("no ready");
   AST_UNMAPPED: assert property (s_bad ##1 s_acc |-> pslverr && prdata == 32'h0)
      else $error("unmapped accepted");
endmodule : esg_checker
bind esg_top esg_checker u_chk (.*);

//--- verification/esg_bus_node.sv
`timescale 1ns/1ps
module esg_bus_node (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic [7:0] cmd_pattern,
   input wire logic       cmd_valid,
   input wire logic [7:0] cmd_enable,
   output logic     [7:0] rx_value
);
   // a node only hears objects that are enabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) rx_value <= 8'h00;
      else if (cmd_valid) rx_value <= cmd_pattern & cmd_enable;
   end
endmodule : esg_bus_node

//--- verification/tb_edge_sequence_generator.sv
`timescale 1ns/1ps
module tb_edge_sequence_generator;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        short_press = 1'b0, long_press = 1'b0, er;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd;
   wire         pready, pslverr, cmd_valid;
   wire  [31:0] prdata;
   wire  [7:0]  cmd_pattern, cmd_enable, rx_value;
   int          bad_count = 0;
   int          checks = 0;
   always #2 pclk = ~pclk;
   esg_top #(.N_OUT(8), .TBL_DEPTH(16)) dut (.*);
   esg_bus_node node (.*);
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask : cmp
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      cmp(rd, exp);
   endtask : rc
   task automatic press(input logic l, input logic [7:0] exp);
      @(posedge pclk);
      short_press <= !l;
      long_press  <= l;
      @(posedge pclk);
      short_press <= 1'b0;
      long_press  <= 1'b0;
      #1;
      cmp(cmd_valid, 1'b1);
      cmp(cmd_pattern, exp);
      @(posedge pclk);
      #1;
      cmp(rx_value, exp);
   endtask : press
   task automatic complete_run;
      if (bad_count == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : complete_run
   initial begin
      #20000;
      bad_count++;
      complete_run();
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      cmp(cmd_enable, 8'h03);
      rc(12'h004, 32'h2);
      rc(12'h008, 32'h2);
      rc(12'h00C, 32'h1);
      for (int o = 0; o < 8; o++) rc(12'h020 + 12'(4 * o), 32'hFFFF);
      apb(1'b1, 12'h004, 32'h3);
      for (int i = 1; i <= 9; i++) press(1'b0, 8'(i % 8));
      apb(1'b1, 12'h00C, 32'h5);
      press(1'b1, 8'h05);
      press(1'b0, 8'h06);
      apb(1'b1, 12'h004, 32'h9);
      apb(1'b1, 12'h004, 32'h8);
      rc(12'h004, 32'h8);
      cmp(cmd_enable, 8'hFF);
      apb(1'b1, 12'h00C, 32'h100);
      apb(1'b1, 12'h00C, 32'h101);
      rc(12'h00C, 32'h100);
      press(1'b1, 8'h00);
      press(1'b0, 8'h01);
      apb(1'b1, 12'h004, 32'h3);
      apb(1'b1, 12'h008, 32'h10);
      apb(1'b1, 12'h008, 32'h11);
      rc(12'h008, 32'h10);
      apb(1'b1, 12'h008, 32'h3);
      apb(1'b1, 12'h020, 32'h5);
      apb(1'b1, 12'h024, 32'h2);
      apb(1'b1, 12'h028, 32'h6);
      apb(1'b1, 12'h000, 32'h1);
      press(1'b0, 8'h01);
      press(1'b0, 8'h06);
      press(1'b0, 8'h05);
      press(1'b0, 8'h01);
      press(1'b1, 8'h01);
      press(1'b0, 8'h06);
      // status: last pattern 06, count 01 left from count mode, next index 2
      rc(12'h010, 32'h0002_0106);
      cmp(er, 1'b0);
      apb(1'b1, 12'h010, 32'h0000_0000);
      cmp(er, 1'b1);
      rc(12'h0FC, 32'h0);
      cmp(er, 1'b1);
      complete_run();
   end
endmodule : tb_edge_sequence_generator
